/* core/sbsc_pkg.sv */
/*
 Shared constants and types for the synchronous burst SRAM control.
 Assumes every consumer imports the whole package.
*/
package sbsc_pkg;
   localparam int LANE_W = 9;
   localparam int LANES_X36 = 4;
   localparam int ADDR_W_DEF = 4;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;

   typedef enum logic [2:0] {
      OP_DESEL = 3'b000,
      OP_RD_EXT = 3'b001,
      OP_WR_EXT = 3'b010,
      OP_RD_NEXT = 3'b011,
      OP_WR_NEXT = 3'b100,
      OP_RD_CUR = 3'b101,
      OP_WR_CUR = 3'b110
   } sbsc_op_t;
endpackage

/* core/sbsc_burst_if.sv */
/*
 Bundle between the cycle decoder and the 2-bit burst counter.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/1ns
interface sbsc_burst_if;
   import sbsc_pkg::*;
   logic load;
   logic step;
   logic interleave;
   logic [CNT_W-1:0] start_low;
   logic [CNT_W-1:0] cur_low;
   logic [CNT_W-1:0] next_low;
   logic [CNT_W-1:0] cnt;
   modport ctl (output load, step, interleave, start_low,
      input cur_low, next_low, cnt);
   modport ctr (input load, step, interleave, start_low,
      output cur_low, next_low, cnt);
endinterface

/* core/sbsc_burst_ctr.sv */
/*
 Two-bit burst counter giving the low address bits in linear or
 interleaved order. Assumes load and step are never both high.
*/
`timescale 1ns/1ns
module sbsc_burst_ctr
   import sbsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   sbsc_burst_if.ctr bif
);
   logic [CNT_W-1:0] base_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_inc;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         base_reg <= CNT_RST;
         cnt_reg <= CNT_RST;
      end
      else if (bif.load)
      begin
         base_reg <= bif.start_low;
         cnt_reg <= CNT_RST;
      end
      else if (bif.step)
         cnt_reg <= cnt_inc;
   end

   assign cnt_inc = cnt_reg + CNT_ONE;
   assign bif.cnt = cnt_reg;
   assign bif.cur_low = bif.interleave ? (base_reg ^ cnt_reg)
      : CNT_W'(base_reg + cnt_reg);
   assign bif.next_low = bif.interleave ? (base_reg ^ cnt_inc)
      : CNT_W'(base_reg + cnt_inc);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_fresh;
      bif.load;
   endsequence
   sequence s_four_steps;
      bif.step [*4];
   endsequence
   sequence s_ilv_first_step;
      (bif.load && bif.interleave) ##1 (bif.step && bif.interleave);
   endsequence

   AST_WRAP_FIFTH: assert property (
      s_fresh ##1 s_four_steps |=> bif.cnt == CNT_RST)
      else $error("burst count did not wrap after four steps");
   AST_ILV_ORDER: assert property (
      s_ilv_first_step |=>
      bif.cur_low == ($past(bif.start_low, 2) ^ CNT_ONE))
      else $error("interleaved second address wrong");
   AST_LIN_ORDER: assert property (
      (bif.step && !bif.interleave && !bif.load) |=>
      bif.cur_low == CNT_W'($past(bif.cur_low) + CNT_ONE))
      else $error("linear low bits did not increment");
endmodule // sbsc_burst_ctr

/* core/sbsc_top.sv */
/*
 Synchronous burst SRAM control with flip-flop storage: cycle decode,
 burst addressing, byte writes and data pin steering.
 Assumes all inputs synchronous to ref_clk except out_enable_n and the asynchronous reset arst_n.
*/
`timescale 1ns/1ns
module sbsc_top
   import sbsc_pkg::*;
#(
   parameter int LANES = LANES_X36,
   parameter int ADDR_W = ADDR_W_DEF
)(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic chip_select_n,
   input wire logic cpu_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic all_bytes_write_n,
   input wire logic byte_select_write_n,
   input wire logic [LANES-1:0] lane_write_n,
   input wire logic burst_order_sel_n,
   input wire logic flowthru_sel_n,
   input wire logic out_enable_n,
   input wire logic [LANES*LANE_W-1:0] dq_in,
   output logic [LANES*LANE_W-1:0] dq_out,
   output logic dq_oe
);
   localparam int DW = LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;

   sbsc_op_t op;
   logic wr_dec;
   logic is_wr;
   logic is_rd;
   logic [LANES-1:0] byte_en;
   logic [ADDR_W-1:0] eff_addr;
   logic [ADDR_W-1:0] hi_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic rd_act_reg;
   logic pipe_act_reg;
   logic [DW-1:0] pipe_data_reg;
   logic [DW-1:0] mem_reg [DEPTH];

   sbsc_burst_if bif ();

   sbsc_burst_ctr u_ctr (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .bif(bif)
   );

   always_comb
   begin
      wr_dec = !all_bytes_write_n
         || (!byte_select_write_n && !(&lane_write_n));
      if (!all_bytes_write_n)
         byte_en = '1;
      else if (!byte_select_write_n)
         byte_en = ~lane_write_n;
      else
         byte_en = '0;
      if (chip_select_n && !ctrl_addr_strobe_n)
         op = OP_DESEL;
      else if (!chip_select_n && !cpu_addr_strobe_n)
         op = OP_RD_EXT;
      else if (!chip_select_n && !ctrl_addr_strobe_n)
         op = wr_dec ? OP_WR_EXT : OP_RD_EXT;
      else if (!burst_step_n)
         op = wr_dec ? OP_WR_NEXT : OP_RD_NEXT;
      else
         op = wr_dec ? OP_WR_CUR : OP_RD_CUR;
   end

   always_comb
   begin
      is_wr = 1'b0;
      is_rd = 1'b0;
      case (op)
         OP_DESEL: ;
         OP_RD_EXT, OP_RD_NEXT, OP_RD_CUR: is_rd = 1'b1;
         OP_WR_EXT, OP_WR_NEXT, OP_WR_CUR: is_wr = 1'b1;
         default: ;
      endcase
   end

   assign bif.load = (op == OP_RD_EXT) || (op == OP_WR_EXT);
   assign bif.step = (op == OP_RD_NEXT) || (op == OP_WR_NEXT);
   assign bif.interleave = burst_order_sel_n;
   assign bif.start_low = addr[CNT_W-1:0];

   always_comb
   begin
      if (bif.load)
         eff_addr = addr;
      else if (bif.step)
         eff_addr = {hi_reg[ADDR_W-1:CNT_W], bif.next_low};
      else
         eff_addr = {hi_reg[ADDR_W-1:CNT_W], bif.cur_low};
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         hi_reg <= '0;
      else if (bif.load)
         hi_reg <= addr;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int j = 0; j < DEPTH; j++)
            mem_reg[j] <= '0;
      end
      else if (is_wr)
      begin
         for (int i = 0; i < LANES; i++)
            if (byte_en[i])
               mem_reg[eff_addr][i*LANE_W +: LANE_W] <=
                  dq_in[i*LANE_W +: LANE_W];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_act_reg <= 1'b0;
         rd_addr_reg <= '0;
      end
      else
      begin
         rd_act_reg <= is_rd;
         rd_addr_reg <= eff_addr;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pipe_act_reg <= 1'b0;
         pipe_data_reg <= '0;
      end
      else
      begin
         pipe_act_reg <= rd_act_reg;
         pipe_data_reg <= mem_reg[rd_addr_reg];
      end
   end

   // Output enable must act without the clock, so not registered
   // driver gating
   assign dq_oe = (flowthru_sel_n ? pipe_act_reg : rd_act_reg)
      && !out_enable_n;
   assign dq_out = flowthru_sel_n ? pipe_data_reg : mem_reg[rd_addr_reg];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_write;
      is_wr;
   endsequence
   sequence s_cpu_load;
      !chip_select_n && !cpu_addr_strobe_n;
   endsequence

   AST_DESEL_QUIET: assert property (
      (chip_select_n && !ctrl_addr_strobe_n) |=> !rd_act_reg)
      else $error("deselect cycle marked as read");
   AST_CPU_LOAD: assert property (
      s_cpu_load |=> rd_act_reg && rd_addr_reg == $past(addr))
      else $error("cpu strobe did not load a read");
   AST_CTRL_LOAD: assert property (
      (!chip_select_n && cpu_addr_strobe_n && !ctrl_addr_strobe_n
      && wr_dec) |=> !rd_act_reg && hi_reg == $past(addr))
      else $error("controller strobe write not loaded");
   AST_WRITE_HIGHZ: assert property (
      (s_write ##1 flowthru_sel_n[*2]) |-> !dq_oe)
      else $error("pins driven after a write");
   AST_GLOBAL_WRITE: assert property (
      (is_wr && !all_bytes_write_n) |=>
      mem_reg[$past(eff_addr)] == $past(dq_in))
      else $error("global write missed a byte");
   AST_READ_DRIVE: assert property (
      (is_rd && !flowthru_sel_n) ##1 (!out_enable_n && !flowthru_sel_n)
      |-> dq_oe)
      else $error("read cycle not driving");
   AST_OE_OFF: assert property (
      out_enable_n |-> !dq_oe)
      else $error("drivers on with output enable high");
   AST_DUMMY_STEP: assert property (
      (op == OP_RD_NEXT && out_enable_n) |=>
      bif.cnt == CNT_W'($past(bif.cnt) + CNT_ONE))
      else $error("dummy read did not advance");
   AST_SUSPEND_HOLD: assert property (
      (op == OP_RD_CUR || op == OP_WR_CUR) |=> $stable(bif.cnt))
      else $error("suspend moved the counter");
   AST_UPPER_HOLD: assert property (
      (op == OP_RD_NEXT) |=>
      rd_addr_reg[ADDR_W-1:CNT_W] == $past(hi_reg[ADDR_W-1:CNT_W]))
      else $error("burst changed upper address bits");
   AST_PIPE_DELAY: assert property (
      (rd_act_reg && flowthru_sel_n && !out_enable_n) ##1
      (flowthru_sel_n && !out_enable_n) |-> dq_oe)
      else $error("pipeline read not one cycle later");
endmodule // sbsc_top

/* verif/sbsc_host.sv */
/*
 Bus master model for the burst SRAM control pins, driven by task calls.
 Assumes one caller issuing at most one cycle per clock.
*/
`timescale 1ns/1ns
module sbsc_host
(
   input wire logic ref_clk,
   output logic chip_select_n,
   output logic cpu_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_step_n,
   output logic all_bytes_write_n,
   output logic byte_select_write_n,
   output logic [3:0] lane_write_n,
   output logic out_enable_n,
   output logic [3:0] addr,
   output logic [35:0] dq_in
);
   initial
   begin
      {chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
         all_bytes_write_n, byte_select_write_n, lane_write_n,
         out_enable_n} = 11'h6FE;
      addr = 4'h0;
      dq_in = 36'h0;
   end

   task automatic issue(input logic [10:0] c, input logic [3:0] a,
      input logic [35:0] d);
      logic wr;
      @(posedge ref_clk);
      wr = !c[6] || (!c[5] && c[4:1] != 4'hF);
      {chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
         all_bytes_write_n, byte_select_write_n, lane_write_n,
         out_enable_n} <= c;
      addr <= a;
      // data only on writes
      // Undriven lines toggle so stale data never looks valid
      dq_in <= wr ? d : ~dq_in;
   endtask
endmodule // sbsc_host

/* verif/tb.sv */
/*
 Self-checking bench for sbsc_top: reference memory and burst model.
 Assumes sbsc_host drives the bus; LANES 4, ADDR_W 4.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end end
module tb;
   import sbsc_pkg::*;
   localparam logic [10:0] DESEL = 11'h6FE;
   localparam logic [10:0] WR_ALL = 11'h2BE;
   localparam logic [10:0] RD_LD = 11'h2FE;
   localparam logic [10:0] CPU_LD = 11'h1C0;
   localparam logic [10:0] CONT = 11'h77E;
   localparam logic [10:0] HOLD = 11'h3FE;
   localparam logic [10:0] DUMMY = 11'h37F;
   localparam logic [10:0] BYTE_WR = 11'h354;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic burst_order_sel_n = 1'b0;
   logic flowthru_sel_n = 1'b0;
   logic cs_n, cpu_n, ctrl_n, step_n, gw_n, bw_n, oe_n, dq_oe;
   logic [3:0] lanes_n, addr;
   logic [35:0] dq_in, dq_out;
   logic [35:0] mem_ref [16] = '{default: 36'h0};
   logic [3:0] base_reg = 4'h0;
   logic [1:0] cnt_reg = 2'h0;
   logic rd_h [2] = '{1'b0, 1'b0};
   logic [35:0] dat_h [2];
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int idx;

   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   sbsc_host i_host (.ref_clk(ref_clk), .chip_select_n(cs_n),
      .cpu_addr_strobe_n(cpu_n), .ctrl_addr_strobe_n(ctrl_n),
      .burst_step_n(step_n), .all_bytes_write_n(gw_n),
      .byte_select_write_n(bw_n), .lane_write_n(lanes_n),
      .out_enable_n(oe_n), .addr(addr), .dq_in(dq_in));

   sbsc_top #(.LANES(4), .ADDR_W(4)) i_dut (.ref_clk(ref_clk),
      .arst_n(arst_n), .addr(addr), .chip_select_n(cs_n),
      .cpu_addr_strobe_n(cpu_n), .ctrl_addr_strobe_n(ctrl_n),
      .burst_step_n(step_n), .all_bytes_write_n(gw_n),
      .byte_select_write_n(bw_n), .lane_write_n(lanes_n),
      .burst_order_sel_n(burst_order_sel_n),
      .flowthru_sel_n(flowthru_sel_n), .out_enable_n(oe_n),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

   function automatic logic [3:0] burst_addr(input logic [3:0] b,
      input logic [1:0] n, input logic il);
      return {b[3:2], il ? b[1:0] ^ n : b[1:0] + n};
   endfunction

   task automatic run(input logic [10:0] c, input logic [3:0] a,
      input logic [35:0] d);
      logic w, acc;
      logic [3:0] ea;
      i_host.issue(c, a, d);
      @(negedge ref_clk);
      // Pipeline shows reads one cycle later than flow-through
      idx = flowthru_sel_n ? 1 : 0;
      `CHK(dq_oe, rd_h[idx] & ~oe_n)
      if (rd_h[idx] && !oe_n)
         `CHK(dq_out, dat_h[idx])
      w = !c[6] || (!c[5] && c[4:1] != 4'hF);
      acc = !(c[10] && !c[8]);
      if (!c[10] && (!c[9] || !c[8]))
      begin
         base_reg = a;
         cnt_reg = 2'h0;
         if (!c[9])
            w = 1'b0;
      end
      else if (acc && !c[7])
         cnt_reg = cnt_reg + 2'h1;
      ea = burst_addr(base_reg, cnt_reg, burst_order_sel_n);
      for (int i = 0; i < 4; i++)
         if (acc && w && (!c[6] || !c[i+1]))
            mem_ref[ea][9*i+:9] = d[9*i+:9];
      rd_h[1] = rd_h[0];
      dat_h[1] = dat_h[0];
      rd_h[0] = acc && !w;
      dat_h[0] = mem_ref[ea];
   endtask

   function automatic logic [35:0] rnd36();
      return 36'({$urandom(), $urandom()});
   endfunction

   task automatic set_mode(input logic flow, input logic order);
      run(DESEL, 4'h0, 36'h0);
      run(DESEL, 4'h0, 36'h0);
      @(posedge ref_clk);
      flowthru_sel_n <= flow;
      burst_order_sel_n <= order;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         results();
      end
   end

   initial
   begin
      void'($urandom(38));
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 16; i++)
         run(WR_ALL, 4'(i), rnd36());
      for (int m = 0; m < 4; m++)
      begin
         set_mode(m[1], m[0]);
         run(CPU_LD, 4'h6, rnd36());
         repeat (4) run(CONT, 4'h0, 36'h0);
         run(HOLD, 4'h0, 36'h0);
         run(DUMMY, 4'h0, 36'h0);
         run(BYTE_WR, 4'h0, rnd36());
         run(RD_LD, 4'h6, 36'h0);
         repeat (4) run(CONT, 4'h0, 36'h0);
      end
      for (int m = 0; m < 4; m++)
      begin
         set_mode(m[0], m[1]);
         // random mix of all cycle kinds
         repeat (250)
            run({10'($urandom()), $urandom() % 4 == 0}, 4'($urandom()),
               rnd36());
      end
      results();
   end
endmodule // tb
